// ---- logic/trf_defines.svh ----
`ifndef TRF_DEFINES_SVH
`define TRF_DEFINES_SVH

// ----------------------------------------
// result format limits
// ----------------------------------------
`define TRF_MIN_DEG (-64)
`define TRF_STD_MAX_DEG 127
`define TRF_EXT_MAX_DEG 191
`define TRF_EXT_OFFSET 64
`define TRF_STD_FLOOR_CODE 8'hC0
`define TRF_STD_CEIL_CODE 8'h7F
`define TRF_EXT_FLOOR_CODE 8'h00
`define TRF_EXT_CEIL_CODE 8'hFF

// ----------------------------------------
// field positions and range reset value
// ----------------------------------------
`define TRF_FRAC_BITS 4
`define TRF_LO_FAULT_BIT 0
`define TRF_RANGE_RESET 1'b0

// ----------------------------------------
// timing
// ----------------------------------------
`define TRF_CLK_PERIOD_NS 5
`define TRF_TIMEOUT_MS 30
`define TRF_TIMEOUT_CYC ((`TRF_TIMEOUT_MS * 1000000) / `TRF_CLK_PERIOD_NS)

`endif

// ---- logic/trf_pkg.sv ----
`default_nettype none
package trf_pkg;

   typedef enum logic {
      TRF_RANGE_STD = 1'b0,
      TRF_RANGE_EXT = 1'b1
   } trf_range_e;

   typedef enum logic [1:0] {
      TRF_TO_IDLE = 2'b00,
      TRF_TO_WATCH = 2'b01,
      TRF_TO_TRIPPED = 2'b10
   } trf_to_state_e;

endpackage
`default_nettype wire

// ---- logic/trf_timeout.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "trf_defines.svh"

module trf_timeout #(
   parameter int TIMEOUT_CYC = `TRF_TIMEOUT_CYC
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic bus_active,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic serial_reset
);

   // ----------------------------------------
   // stall watchdog
   // ----------------------------------------
   trf_pkg::trf_to_state_e state_q, state_d;
   logic [31:0] cnt_q, cnt_d;
   logic serial_reset_q, serial_reset_d;

   wire line_low = !scl_in || !sda_in;
   wire expired = (cnt_q == 32'(TIMEOUT_CYC - 1));

   // a tripped watchdog stays quiet until the host frees the bus, so one
   // stall gives exactly one interface reset
   always_comb begin
      state_d = state_q;
      cnt_d = 32'h0000_0000;
      serial_reset_d = 1'b0;
      case (state_q)
         trf_pkg::TRF_TO_IDLE: begin
            if (bus_active) begin
               state_d = trf_pkg::TRF_TO_WATCH;
            end
         end
         trf_pkg::TRF_TO_WATCH: begin
            if (!bus_active) begin
               state_d = trf_pkg::TRF_TO_IDLE;
            end else if (line_low && expired) begin
               state_d = trf_pkg::TRF_TO_TRIPPED;
               serial_reset_d = 1'b1;
            end else if (line_low) begin
               cnt_d = cnt_q + 32'h0000_0001;
            end
         end
         trf_pkg::TRF_TO_TRIPPED: begin
            if (!bus_active) begin
               state_d = trf_pkg::TRF_TO_IDLE;
            end
         end
         default: begin
            state_d = trf_pkg::TRF_TO_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         state_q <= trf_pkg::TRF_TO_IDLE;
         cnt_q <= 32'h0000_0000;
         serial_reset_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         serial_reset_q <= serial_reset_d;
      end
   end

   assign serial_reset = serial_reset_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   chk_timeout_count: assert property (@(posedge clk_sys) disable iff (!reset_n)
      $rose(serial_reset) |-> $past(cnt_q) == 32'(TIMEOUT_CYC - 1) && $past(line_low))
      else $error("interface reset without full low-line stall");

   chk_timeout_single: assert property (@(posedge clk_sys) disable iff (!reset_n)
      serial_reset |=> !serial_reset)
      else $error("interface reset longer than one cycle");

endmodule

`default_nettype wire

// ---- logic/trf_formatter.sv ----
// How it works
// - default high byte is signed whole degrees
// - default format floors below -64 at C0
// - default format saturates above 127 at 7F
// - range select high picks extended offset format
// - range change takes effect next conversion only
// - extended high byte adds offset of 64
// - extended codes span -64 to 191 degrees
// - local channel plus one to three remote
// - low byte upper nibble holds sixteenth degrees
// - remote fault sets bit 0 of result
// - 30 ms low stall resets serial interface
`timescale 1ns/100ps
`default_nettype none
`include "trf_defines.svh"

module trf_formatter #(
   parameter int NUM_REMOTE = 3,
   parameter int RAW_W = 16,
   parameter int TIMEOUT_CYC = `TRF_TIMEOUT_CYC,
   localparam int NUM_CH = NUM_REMOTE + 1,
   localparam int CH_W = (NUM_CH > 1) ? $clog2(NUM_CH) : 1
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic range_sel,
   input wire logic conv_start,
   input wire logic conv_done,
   input wire logic [CH_W-1:0] conv_chan,
   input wire logic signed [RAW_W-1:0] conv_raw,
   input wire logic conv_fault,
   input wire logic bus_active,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic range_active,
   output logic done,
   output logic [CH_W-1:0] done_chan,
   output logic [7:0] done_hi,
   output logic [7:0] done_lo,
   output logic [8*NUM_CH-1:0] result_hi,
   output logic [8*NUM_CH-1:0] result_lo,
   output logic serial_reset
);

   // ----------------------------------------
   // formatting
   // ----------------------------------------
   // raw conversion is signed sixteenths of a degree; whole degrees are
   // the arithmetic shift, so the fraction is always a positive addend
   function automatic logic [15:0] fmt_result(input logic signed [RAW_W-1:0] raw,
                                              input logic ext, input logic fault);
      int whole;
      int biased;
      logic [7:0] hi;
      logic [3:0] frac;
      logic [7:0] lo;
      whole = int'(raw >>> `TRF_FRAC_BITS);
      biased = whole + (ext ? `TRF_EXT_OFFSET : 0);
      frac = raw[`TRF_FRAC_BITS-1:0];
      if (whole < `TRF_MIN_DEG) begin
         hi = ext ? `TRF_EXT_FLOOR_CODE : `TRF_STD_FLOOR_CODE;
         frac = 4'h0;
      end else if (!ext && whole > `TRF_STD_MAX_DEG) begin
         hi = `TRF_STD_CEIL_CODE;
         frac = 4'h0;
      end else if (ext && whole > `TRF_EXT_MAX_DEG) begin
         hi = `TRF_EXT_CEIL_CODE;
         frac = 4'h0;
      end else begin
         hi = 8'(biased);
      end
      lo = {frac, 4'h0};
      lo[`TRF_LO_FAULT_BIT] = fault;
      return {hi, lo};
   endfunction

   // ----------------------------------------
   // range latch
   // ----------------------------------------
   // sampled only at conversion start so a conversion in flight keeps
   // the format it began with
   trf_pkg::trf_range_e range_q, range_d;
   assign range_d = conv_start ? trf_pkg::trf_range_e'(range_sel) : range_q;

   wire [15:0] fmt_w = fmt_result(conv_raw, range_q == trf_pkg::TRF_RANGE_EXT, conv_fault);
   wire signed [RAW_W-1:0] whole_w = conv_raw >>> `TRF_FRAC_BITS;

   // ----------------------------------------
   // result storage
   // ----------------------------------------
   logic [7:0] hi_q [NUM_CH];
   logic [7:0] lo_q [NUM_CH];
   logic done_q;
   logic [CH_W-1:0] done_chan_q;
   logic [7:0] done_hi_q;
   logic [7:0] done_lo_q;

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         range_q <= trf_pkg::trf_range_e'(`TRF_RANGE_RESET);
         done_q <= 1'b0;
         done_chan_q <= '0;
         done_hi_q <= 8'h00;
         done_lo_q <= 8'h00;
      end else begin
         range_q <= range_d;
         done_q <= conv_done;
         if (conv_done) begin
            done_chan_q <= conv_chan;
            done_hi_q <= fmt_w[15:8];
            done_lo_q <= fmt_w[7:0];
         end
      end
   end

   // each channel owns its own pair; out-of-range channel numbers are dropped
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
         always_ff @(posedge clk_sys) begin
            if (!reset_n) begin
               hi_q[ch] <= 8'h00;
               lo_q[ch] <= 8'h00;
            end else if (conv_done && conv_chan == CH_W'(ch)) begin
               hi_q[ch] <= fmt_w[15:8];
               lo_q[ch] <= fmt_w[7:0];
            end
         end
         assign result_hi[8*ch +: 8] = hi_q[ch];
         assign result_lo[8*ch +: 8] = lo_q[ch];
      end
   endgenerate

   assign range_active = range_q;
   assign done = done_q;
   assign done_chan = done_chan_q;
   assign done_hi = done_hi_q;
   assign done_lo = done_lo_q;

   // ----------------------------------------
   // serial stall watchdog
   // ----------------------------------------
   trf_timeout #(
      .TIMEOUT_CYC(TIMEOUT_CYC)
   ) u_timeout (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .bus_active(bus_active),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .serial_reset(serial_reset)
   );

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   sequence s_std_conv;
      conv_done && range_q == trf_pkg::TRF_RANGE_STD;
   endsequence

   sequence s_ext_conv;
      conv_done && range_q == trf_pkg::TRF_RANGE_EXT;
   endsequence

   chk_std_code: assert property (s_std_conv ##0
      (whole_w >= `TRF_MIN_DEG && whole_w <= `TRF_STD_MAX_DEG)
      |=> done_hi == $past(whole_w[7:0]))
      else $error("standard code differs from whole degrees");

   chk_std_floor: assert property (s_std_conv ##0 whole_w < `TRF_MIN_DEG
      |=> done_hi == 8'hC0)
      else $error("standard cold result not floored");

   chk_std_ceil: assert property (s_std_conv ##0 whole_w > `TRF_STD_MAX_DEG
      |=> done_hi == 8'h7F)
      else $error("standard hot result not saturated");

   chk_ext_offset: assert property (s_ext_conv ##0
      (whole_w >= `TRF_MIN_DEG && whole_w <= `TRF_EXT_MAX_DEG)
      |=> done_hi == 8'($past(whole_w[7:0]) + 8'h40))
      else $error("extended code lacks offset");

   chk_ext_clamp: assert property (s_ext_conv ##0 whole_w > `TRF_EXT_MAX_DEG
      |=> done_hi == 8'hFF)
      else $error("extended hot result not saturated");

   chk_range_hold: assert property (!conv_start |=> $stable(range_q))
      else $error("range changed outside conversion start");

   chk_range_take: assert property (conv_start
      |=> range_q == $past(range_sel))
      else $error("range select not taken at conversion start");

   chk_frac_fault: assert property (conv_done && !conv_fault &&
      whole_w >= `TRF_MIN_DEG && whole_w <= `TRF_STD_MAX_DEG
      |=> done_lo[7:4] == $past(conv_raw[3:0]) && !done_lo[0])
      else $error("fraction nibble wrong");

   chk_fault_flag: assert property (conv_done && conv_fault |=> done && done_lo[0])
      else $error("fault flag missing");

   chk_chan_store: assert property (conv_done && conv_chan == '0
      |=> result_hi[7:0] == done_hi && result_lo[7:0] == done_lo)
      else $error("local channel result not stored");

   chk_ext_floor: assert property (s_ext_conv ##0 whole_w < `TRF_MIN_DEG
      |=> done_hi == 8'h00)
      else $error("extended cold result not floored");

   // done mirrors the accepted conversion one cycle later, whatever the channel
   chk_done_pulse: assert property (conv_done |=> done && done_chan == $past(conv_chan))
      else $error("done pulse or channel wrong");

   // a channel number past the last channel must leave every stored pair alone
   chk_chan_refused: assert property (conv_done && int'(conv_chan) >= NUM_CH
      |=> $stable(result_hi) && $stable(result_lo))
      else $error("refused channel overwrote a result");

endmodule

`default_nettype wire

// ---- dv/trf_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// serial host seen as line levels
// ----------------------------------------
module trf_host_model (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic go,
   input wire logic [1:0] stall,
   output logic bus_active,
   output logic scl_in,
   output logic sda_in
);
   logic tog_q;
   always_ff @(posedge clk_sys) begin
      if (!reset_n || !go) begin
         tog_q <= 1'b1;
      end else begin
         tog_q <= ~tog_q;
      end
   end
   assign bus_active = go;
   // a released line sits at its pull-up; only a commanded stall holds one low
   assign scl_in = go ? (tog_q & ~stall[0]) : 1'b1;
   assign sda_in = go ? ~stall[1] : 1'b1;
endmodule
`default_nettype wire

// ---- dv/temperature_result_formatter_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module temperature_result_formatter_tb_top;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic range_sel = 1'b0;
   logic conv_start = 1'b0;
   logic conv_done = 1'b0;
   logic [1:0] conv_chan = 2'h0;
   logic signed [15:0] conv_raw = 16'h0000;
   logic conv_fault = 1'b0;
   logic go = 1'b0;
   logic [1:0] stall = 2'h0;
   logic bus_active, scl_in, sda_in, range_active, done, serial_reset;
   logic [1:0] done_chan;
   logic [7:0] done_hi, done_lo;
   logic [23:0] result_hi, result_lo;
   int errors = 0;
   int comparisons = 0;
   int tbl[9] = '{-1040, -1024, -1025, -392, -1, 0, 401, 2047, 2400};

   always #2.5 clk_sys = ~clk_sys;

   // two remotes leave channel code 3 unused, so the refused path is reachable
   trf_formatter #(.NUM_REMOTE(2), .RAW_W(16), .TIMEOUT_CYC(8)) dut (
      .clk_sys(clk_sys), .reset_n(reset_n), .range_sel(range_sel),
      .conv_start(conv_start), .conv_done(conv_done), .conv_chan(conv_chan),
      .conv_raw(conv_raw), .conv_fault(conv_fault), .bus_active(bus_active),
      .scl_in(scl_in), .sda_in(sda_in), .range_active(range_active), .done(done),
      .done_chan(done_chan), .done_hi(done_hi), .done_lo(done_lo),
      .result_hi(result_hi), .result_lo(result_lo), .serial_reset(serial_reset)
   );
   trf_host_model host (
      .clk_sys(clk_sys), .reset_n(reset_n), .go(go), .stall(stall),
      .bus_active(bus_active), .scl_in(scl_in), .sda_in(sda_in)
   );

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic wrap_up;
      $display("comparisons %0d, errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // saturated codes carry a zero fraction nibble
   function automatic logic [15:0] fmt(input int d16, input logic ext, input logic flt);
      int w;
      logic [7:0] hi, lo;
      w = d16 >>> 4;
      lo = {d16[3:0], 3'b000, flt};
      hi = ext ? 8'(w + 64) : 8'(w);
      if (w < -64 || w > (ext ? 191 : 127)) begin
         lo[7:4] = 4'h0;
         hi = (w < -64) ? (ext ? 8'h00 : 8'hC0) : (ext ? 8'hFF : 8'h7F);
      end
      return {hi, lo};
   endfunction

   task automatic conv(input logic [1:0] ch, input int d16, input logic flt,
                       input logic st, input logic rs, input logic ext);
      logic [15:0] e;
      e = fmt(d16, ext, flt);
      @(posedge clk_sys);
      conv_done <= 1'b1;
      conv_chan <= ch;
      conv_raw <= d16[15:0];
      conv_fault <= flt;
      conv_start <= st;
      range_sel <= rs;
      @(posedge clk_sys);
      conv_done <= 1'b0;
      conv_start <= 1'b0;
      #1;
      check("done", done, 1);
      check("done_chan", done_chan, ch);
      check("done_hi", done_hi, e[15:8]);
      check("done_lo", done_lo, e[7:0]);
      if (ch < 2'h3) begin
         check("result_hi", result_hi[8*ch+:8], e[15:8]);
         check("result_lo", result_lo[8*ch+:8], e[7:0]);
      end
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic std_format;
      foreach (tbl[i]) conv(2'(i % 3), tbl[i], 1'b0, 1'b0, 1'b0, 1'b0);
      $display("test std_format done");
   endtask

   task automatic channels_fault;
      for (int c = 0; c < 3; c++) conv(2'(c), (c * 10 + 3) * 16 + c, 1'b0, 1'b0, 1'b0, 1'b0);
      conv(2'h3, 1600, 1'b1, 1'b0, 1'b0, 1'b0);
      @(posedge clk_sys);
      #1;
      check("done pulse", done, 0);
      for (int c = 0; c < 3; c++) check("kept", result_hi[8*c+:8], 8'(c * 10 + 3));
      conv(2'h2, 400, 1'b1, 1'b0, 1'b0, 1'b0);
      $display("test channels_fault done");
   endtask

   task automatic range_switch;
      conv(2'h0, 160, 1'b0, 1'b0, 1'b0, 1'b0);
      @(posedge clk_sys);
      range_sel <= 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      check("range without start", range_active, 0);
      conv(2'h1, 400, 1'b0, 1'b1, 1'b1, 1'b0);
      check("range_active", range_active, 1);
      check("stored kept", result_hi[7:0], 8'h0A);
      foreach (tbl[i]) conv(2'(i % 3), tbl[i] + 640, 1'b0, 1'b0, 1'b1, 1'b1);
      conv(2'h0, 3071, 1'b0, 1'b0, 1'b1, 1'b1);
      conv(2'h1, 3072, 1'b0, 1'b0, 1'b1, 1'b1);
      conv(2'h2, -1040, 1'b0, 1'b1, 1'b0, 1'b1);
      conv(2'h2, -1040, 1'b0, 1'b0, 1'b0, 1'b0);
      $display("test range_switch done");
   endtask

   task automatic stall_run(input logic [1:0] which);
      int n;
      int first;
      n = 0;
      first = -1;
      @(posedge clk_sys);
      go <= 1'b1;
      repeat (20) begin
         @(posedge clk_sys);
         #1;
         if (serial_reset === 1'b1) n++;
      end
      check("early serial_reset", n, 0);
      @(posedge clk_sys);
      stall <= which;
      for (int i = 0; i < 30; i++) begin
         @(posedge clk_sys);
         #1;
         if (serial_reset === 1'b1) begin
            n++;
            if (first < 0) first = i;
         end
      end
      check("serial_reset count", n, 1);
      // low is sampled from the first loop edge on; the eighth low edge trips
      check("serial_reset delay", first, 7);
      @(posedge clk_sys);
      go <= 1'b0;
      stall <= 2'h0;
      $display("test stall_run done");
   endtask

   initial begin
      repeat (6) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(posedge clk_sys);
      #1;
      check("reset results", result_hi[15:0], 16'h0000);
      check("reset range", range_active, 0);
      std_format();
      channels_fault();
      range_switch();
      stall_run(2'h1);
      stall_run(2'h2);
      wrap_up();
   end
endmodule
`default_nettype wire
